// [logic/mst_top.sv]
// Modem status and clear-to-send tracking for one serial channel.
// Assumes a classic Wishbone master and a clear-to-send pin from a modem.
//
// How it works
// - Clear-to-send change sets bit 0 flag
// - Bit 4 shows inverted clear-to-send pin
// - Loopback shows request-to-send in bit 4
// - Flow control only when feature bit 7
// - Pin high stops launches after current character
// - Ring, DSR, carrier bits always inactive
// - Status read clears bit 0 only
// - Flag set held until read ends
// - Recurrence during read clears the flag
// - Loopback ignores the external pin
// - Request-to-send changes in loopback raise interrupt
// - Reset clears flag, bit 4 live
// - Control bit 4 selects local loopback
`timescale 1ns/1ps
`default_nettype none
module mst_top
    import mst_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Modem side
    input  wire logic        cts_n_i,
    output logic             rts_n_o,
    output logic             loop_en_o,
    // Transmitter holding path
    input  wire logic        tx_pending_i,
    input  wire logic        tx_busy_i,
    output logic             tx_start_o,
    // Interrupt
    output logic             irq_o
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [7:0]       mcs_q;
    logic [7:0]       mcs_d;
    logic [7:0]       efc_q;
    logic [IRQ_W-1:0] ist_q;
    logic [IRQ_W-1:0] ist_d;
    logic [IRQ_W-1:0] ien_q;
    logic [IRQ_W-1:0] ev;
    logic             cts_n_sync;
    logic             cts_prev_q;
    logic [1:0]       arm_q;
    logic             dcts_q;
    logic             dcts_d;
    logic             pend_q;
    logic             hold_q;
    mst_stat_s        stat;
    mst_tx_s          tx;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire req     = cyc_i & stb_i & ~ack_q;
    wire hit_mls = adr_i == MLS_OFS;
    wire hit_mcs = adr_i == MCS_OFS;
    wire hit_efc = adr_i == EFC_OFS;
    wire hit_ist = adr_i == IST_OFS;
    wire hit_clr = adr_i == ICLR_OFS;
    wire hit_ien = adr_i == IEN_OFS;
    wire wr_lo   = req & we_i & sel_i[0];
    wire wr_mcs  = wr_lo & hit_mcs;
    wire wr_efc  = wr_lo & hit_efc;
    wire wr_clr  = wr_lo & hit_clr;
    wire wr_ien  = wr_lo & hit_ien;
    // Status read spans request to acknowledge
    wire rd_mls  = cyc_i & stb_i & ~we_i & hit_mls;
    wire rd_end  = rd_mls & ack_q;

    // ----------------------------------------------------------------
    // Clear-to-send source
    // ----------------------------------------------------------------
    mst_sync #(
        .W   (1),
        .RST (CTS_N_RST)
    ) u_cts_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (cts_n_i),
        .q_o   (cts_n_sync)
    );

    wire loop    = mcs_q[MCS_LOOP];
    wire cts_pin = ~cts_n_sync;
    // External pin disconnected while looped back
    wire cts_eff = loop ? mcs_q[MCS_RTS] : cts_pin;
    wire armed   = arm_q == ARM_CNT;
    wire chg     = armed & (cts_eff != cts_prev_q);

    // ----------------------------------------------------------------
    // Change flag
    // ----------------------------------------------------------------
    wire rd_hit  = pend_q | chg;
    // Read end: a recurrence clears, a fresh change sets
    wire end_val = rd_hit & ~dcts_q;

    always_comb begin
        dcts_d = dcts_q;
        if (rd_end) begin
            dcts_d = end_val;
        end else if (chg & ~rd_mls) begin
            dcts_d = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dcts_q     <= 1'b0;
            pend_q     <= 1'b0;
            cts_prev_q <= 1'b0;
            arm_q      <= 2'h0;
        end else begin
            dcts_q     <= dcts_d;
            pend_q     <= rd_mls & ~rd_end & rd_hit;
            cts_prev_q <= cts_eff;
            if (!armed) begin
                arm_q <= arm_q + 2'h1;
            end
        end
    end

    assign stat.dcts = dcts_q;
    assign stat.cts  = cts_eff;

    // Unsupported inputs tied inactive: bits 1-3, 5-7 zero
    wire [7:0] mls_word = {3'h0, stat.cts, 3'h0, stat.dcts};

    // ----------------------------------------------------------------
    // Transmit gating
    // ----------------------------------------------------------------
    wire flow_en = efc_q[EFC_HWFC];
    wire hold    = flow_en & ~cts_eff;

    assign tx.pending = tx_pending_i;
    assign tx.busy    = tx_busy_i;
    // A character in flight is never cut short
    assign tx.start   = tx.pending & ~tx.busy & ~hold;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    // Upper control bits locked unless enhanced functions on
    assign mcs_d = efc_q[EFC_ENH] ? dat_i[7:0]
                                  : {mcs_q[7:5], dat_i[4:0]};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mcs_q <= MCS_RST;
            efc_q <= EFC_RST;
            ien_q <= IRQ_RST;
        end else begin
            if (wr_mcs) begin
                mcs_q <= mcs_d;
            end
            if (wr_efc) begin
                efc_q <= dat_i[7:0];
            end
            if (wr_ien) begin
                ien_q <= dat_i[IRQ_W-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status
    // ----------------------------------------------------------------
    assign ev[IRQ_DCTS] = dcts_d & ~dcts_q;
    assign ev[IRQ_HOLD] = hold & ~hold_q;
    // Set wins over a same-cycle clear
    assign ist_d = (ist_q & ~({IRQ_W{wr_clr}} & dat_i[IRQ_W-1:0])) | ev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q  <= IRQ_RST;
            hold_q <= 1'b0;
        end else begin
            ist_q  <= ist_d;
            hold_q <= hold;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------------------------------
    wire [7:0] rd_byte =
        hit_mls ? mls_word :
        hit_mcs ? mcs_q :
        hit_efc ? efc_q :
        hit_ist ? {6'h00, ist_q} :
        hit_ien ? {6'h00, ien_q} : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            if (req & ~we_i) begin
                dat_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign ack_o      = ack_q;
    assign dat_o      = dat_q;
    assign tx_start_o = tx.start;
    assign loop_en_o  = loop;
    // Pin forced inactive while looped back
    assign rts_n_o    = loop | ~mcs_q[MCS_RTS];
    assign irq_o      = |(ist_q & ien_q);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_read_end;
        rd_end;
    endsequence

    sequence s_quiet_end;
        rd_end ##0 !rd_hit;
    endsequence

    chk_dcts_set: assert property (
        chg && !rd_mls |=> dcts_q && ist_q[IRQ_DCTS] | $past(ist_q[IRQ_DCTS])
    ) else $error("change did not set flag");

    chk_cts_live: assert property (
        !loop |-> mls_word[MLS_CTS] == !cts_n_sync
    ) else $error("bit 4 not inverted pin");

    chk_loop_rts: assert property (
        loop_en_o |-> mls_word[MLS_CTS] == mcs_q[MCS_RTS] && rts_n_o
    ) else $error("loopback does not show rts");

    chk_flow_off: assert property (
        !efc_q[EFC_HWFC] |-> tx_start_o == (tx_pending_i && !tx_busy_i)
    ) else $error("gating without flow control");

    chk_flow_stop: assert property (
        efc_q[EFC_HWFC] && !loop && cts_n_sync |-> !tx_start_o
    ) else $error("launch while clear-to-send high");

    chk_unused_bits: assert property (
        ack_o && rd_mls |-> dat_o[7:5] == 3'h0 && dat_o[3:1] == 3'h0
    ) else $error("unsupported status bit set");

    chk_read_clear: assert property (
        s_quiet_end |=> !dcts_q && mls_word[MLS_CTS] == cts_eff
    ) else $error("read did not clear flag");

    chk_hold_off: assert property (
        rd_mls && !ack_q && chg |=> $stable(dcts_q) ##0 pend_q
    ) else $error("flag changed during read");

    chk_recur_clear: assert property (
        s_read_end ##0 dcts_q && rd_hit |=> !dcts_q
    ) else $error("recurrence set flag again");

    chk_loop_ignore: assert property (
        loop && mcs_q[MCS_RTS] == cts_prev_q && !wr_mcs |=> !chg
    ) else $error("pin seen in loopback");

    chk_loop_irq: assert property (
        loop && armed && !rd_mls && wr_mcs && dat_i[MCS_RTS] != mcs_q[MCS_RTS]
            && dat_i[MCS_LOOP] && !dcts_q |=> ##1 dcts_q && ist_q[IRQ_DCTS]
    ) else $error("control write raised no change");

    chk_reset_flag: assert property (disable iff (1'b0)
        rst_i |=> !dcts_q && !ist_q[IRQ_DCTS]
    ) else $error("reset left flag set");

    chk_sync_edge: assert property (
        chg && !loop && !$past(loop) |-> cts_n_sync != $past(cts_n_sync)
    ) else $error("change without pin edge");

endmodule
`default_nettype wire

// [logic/mst_pkg.sv]
// Constants and carrier types for the modem status / clear-to-send block.
// Assumes a 32-bit classic Wishbone register port with byte addresses.
package mst_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] MLS_OFS  = 8'h00;
    localparam logic [7:0] MCS_OFS  = 8'h04;
    localparam logic [7:0] EFC_OFS  = 8'h08;
    localparam logic [7:0] IST_OFS  = 8'h0C;
    localparam logic [7:0] ICLR_OFS = 8'h10;
    localparam logic [7:0] IEN_OFS  = 8'h14;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned MLS_DCTS = 0;
    localparam int unsigned MLS_CTS  = 4;
    localparam int unsigned MCS_RTS  = 1;
    localparam int unsigned MCS_LOOP = 4;
    localparam int unsigned EFC_ENH  = 4;
    localparam int unsigned EFC_HWFC = 7;
    localparam int unsigned IRQ_DCTS = 0;
    localparam int unsigned IRQ_HOLD = 1;
    localparam int unsigned IRQ_W    = 2;

    // ----------------------------------------------------------------
    // Reset values and timing counts
    // ----------------------------------------------------------------
    localparam logic [7:0]       MCS_RST   = 8'h00;
    localparam logic [7:0]       EFC_RST   = 8'h00;
    localparam logic [IRQ_W-1:0] IRQ_RST   = 2'h0;
    localparam logic             CTS_N_RST = 1'h1;
    localparam logic [1:0]       ARM_CNT   = 2'h2;

    // ----------------------------------------------------------------
    // Carrier types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cts;
        logic dcts;
    } mst_stat_s;

    typedef struct packed {
        logic pending;
        logic busy;
        logic start;
    } mst_tx_s;

endpackage

// [logic/mst_sync.sv]
// Two-flop level synchroniser with a constant reset value.
// Assumes the destination clock is clk_i; the input may be asynchronous.
`timescale 1ns/1ps
`default_nettype none
module mst_sync #(
    parameter int unsigned W   = 1,
    parameter logic [W-1:0] RST = '1
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Data
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= RST;
            q_o    <= RST;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule
`default_nettype wire

// [verification/mst_cts_peer.sv]
// Modem-side model driving the active-low clear-to-send line.
// Assumes the bench sets the wanted readiness; lag_i delays the answer.
`timescale 1ns/1ps
`default_nettype none
module mst_cts_peer (
    // Clock
    input  wire logic       clk_i,
    // Bench control
    input  wire logic       want_ready_i,
    input  wire logic [3:0] lag_i,
    // Modem line
    output logic            cts_n_o
);
    logic [3:0] wait_q;

    initial begin
        cts_n_o = 1'h1;
        wait_q  = 4'h0;
    end

    // ------------------------------------------------------------
    // Level line: always driven, follows the wish after lag cycles
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        if (cts_n_o == want_ready_i) begin
            if (wait_q >= lag_i) begin
                cts_n_o <= ~want_ready_i;
                wait_q  <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end else begin
            wait_q <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// [verification/modem_status_cts_tracking_test.sv]
// Self-checking bench for the modem status / clear-to-send block.
// Assumes mst_top with a classic Wishbone port and the modem peer model.
`timescale 1ns/1ps
`default_nettype none
module modem_status_cts_tracking_test
    import mst_pkg::*;
;
    logic        clk, rst, cyc, stb, we, ack, cts_n, rts_n, loop_en;
    logic        tx_pend, tx_busy, tx_start, irq, want_ready, hw, rdy;
    logic [1:0]  seen;
    logic [3:0]  sel, lag;
    logic [7:0]  adr;
    logic [7:0]  ofs [5];
    logic [31:0] wdat, rdat, rdata, rnd;
    int          fail_count, tests_run;

    mst_top uut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .cts_n_i(cts_n), .rts_n_o(rts_n), .loop_en_o(loop_en), .tx_pending_i(tx_pend),
        .tx_busy_i(tx_busy), .tx_start_o(tx_start), .irq_o(irq));
    mst_cts_peer peer (.clk_i(clk), .want_ready_i(want_ready), .lag_i(lag), .cts_n_o(cts_n));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] mls_exp(input logic flag, input logic cts);
        logic [31:0] v;
        v = 32'h0;
        v[MLS_DCTS] = flag;
        v[MLS_CTS] = cts;
        return v;
    endfunction
    function automatic logic tx_exp(input logic pend, busy, hwfc, ready);
        return pend & ~busy & ~(hwfc & ~ready);
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= s;
        do begin
            @(posedge clk);
        end while (ack !== 1'h1);
        rdata = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus(1'h1, a, {24'h0, d}, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a);
        bus(1'h0, a, 32'h0, 4'hF);
    endtask
    task automatic set_cts(input logic ready, input int cycles);
        want_ready <= ready;
        repeat (cycles) @(posedge clk);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Clock, watchdog and scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD t=%0t got=%h exp=%h", $time, 1'h0, 1'h1);
        end_of_test;
    end
    initial begin
        {rst, cyc, stb, we, tx_pend, tx_busy, want_ready} = 7'h41;
        {sel, lag, adr, wdat} = '0;
        fail_count = 0;
        tests_run = 0;
        rnd = 32'h89B65377;
        ofs = '{MLS_OFS, MCS_OFS, EFC_OFS, IST_OFS, IEN_OFS};
        want_ready = 1'h0;
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 5; i++) begin
            rd(ofs[i]);
            chk_word(rdata, 32'h0);
        end
        rd(8'h20);
        chk_word(rdata, 32'h0);
        rnd = lfsr(rnd);
        wr(IEN_OFS, rnd[7:0]);
        bus(1'h1, IEN_OFS, ~rnd, 4'hE);
        rd(IEN_OFS);
        chk_word(rdata, {30'h0, rnd[1:0]});
        wr(IEN_OFS, 8'h00);
        set_cts(1'h1, 8);
        chk_bit(irq, 1'h0);
        rd(IST_OFS);
        chk_bit(rdata[IRQ_DCTS], 1'h1);
        wr(IEN_OFS, 8'h01);
        chk_bit(irq, 1'h1);
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h1, 1'h1));
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h0, 1'h1));
        wr(ICLR_OFS, 8'h01);
        chk_bit(irq, 1'h0);
        // Pin edge placed before, inside and after a status read
        for (int k = 0; k < 6; k++) begin
            set_cts(k[0], k);
            seen = 2'h0;
            repeat (3) begin
                rd(MLS_OFS);
                seen = seen + {1'h0, rdata[MLS_DCTS]};
            end
            chk_word({30'h0, seen}, 32'h1);
            chk_bit(rdata[MLS_CTS], k[0]);
        end
        // Second pin edge inside a read while the flag is still set
        set_cts(1'h0, 6);
        set_cts(1'h1, 2);
        rd(MLS_OFS);
        chk_bit(rdata[MLS_DCTS], 1'h1);
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h0, 1'h1));
        wr(MCS_OFS, 8'h12);
        chk_bit(loop_en, 1'h1);
        chk_bit(rts_n, 1'h1);
        repeat (6) @(posedge clk);
        rd(MLS_OFS);
        chk_bit(rdata[MLS_CTS], 1'h1);
        wr(ICLR_OFS, 8'h01);
        set_cts(1'h0, 10);
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h0, 1'h1));
        chk_bit(irq, 1'h0);
        wr(MCS_OFS, 8'h10);
        repeat (6) @(posedge clk);
        chk_bit(irq, 1'h1);
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h1, 1'h0));
        wr(MCS_OFS, 8'h02);
        chk_bit(rts_n, 1'h0);
        chk_bit(loop_en, 1'h0);
        repeat (6) @(posedge clk);
        rd(MLS_OFS);
        chk_word(rdata, mls_exp(1'h0, 1'h0));
        // Flow control gating, first pass forced to the stopping case
        for (int i = 0; i < 12; i++) begin
            rnd = lfsr(rnd);
            hw = (i == 0) | ((i != 1) & rnd[0]);
            rdy = (i != 0) & rnd[1];
            lag <= rnd[7:4];
            wr(EFC_OFS, {hw, 7'h0});
            set_cts(rdy, 24);
            for (int j = 0; j < 4; j++) begin
                rnd = lfsr(rnd);
                tx_pend <= rnd[2] | (j == 0);
                tx_busy <= rnd[3] & (j != 0);
                @(negedge clk);
                chk_bit(tx_start, tx_exp(rnd[2] | (j == 0), rnd[3] & (j != 0), hw, rdy));
                @(posedge clk);
            end
        end
        end_of_test;
    end
endmodule
`default_nettype wire
